// [bench/ius_state_regs_test.sv]
// Self-checking bench for the integer core state registers.
// Assumes the design package, the storage interface and the design modules are compiled first.
`timescale 1ns/1ps
module ius_state_regs_test;
    // Operation strobes, one bit each, in the order of the op vector below.
    localparam logic [12:0] RS = 13'h1000, WS = 13'h0800, RM = 13'h0400, WM = 13'h0200;
    localparam logic [12:0] FL = 13'h0100, SB = 13'h0080, SV = 13'h0040, RE = 13'h0020;
    localparam logic [12:0] TR = 13'h0010, TK = 13'h0008, EX = 13'h0004, CP = 13'h0002, FP = 13'h0001;
    // Output pulses: read valid, refused, overflow, underflow, coproc, float, interrupt.
    localparam logic [6:0]  F_RD = 7'h40, F_PT = 7'h20, F_OV = 7'h10, F_UN = 7'h08;
    localparam logic [6:0]  F_CP = 7'h04, F_FP = 7'h02, F_IA = 7'h01;

    logic        mclk      = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [12:0] op        = 13'h0;
    logic [31:0] wr_data   = 32'h0;
    logic [31:0] alu_a     = 32'h0;
    logic [31:0] alu_b     = 32'h0;
    logic [3:0]  irq_level = 4'h0;
    logic [31:0] rd_data;
    logic [31:0] psr_out;
    logic [31:0] wim_out;
    logic        rd_valid, priv_trap, win_ovf, win_unf, irq_accept, error_mode, cp_trap, fp_trap;
    int          errors    = 0;
    int          compares  = 0;
    int          seed      = 32'h4e46;
    logic [70:0] notes[$];
    wire  [6:0]  ev        = {rd_valid, priv_trap, win_ovf, win_unf, cp_trap, fp_trap, irq_accept};

    always #5 mclk = ~mclk;

    ius_state_regs dut_u (
        .mclk(mclk), .sys_rst(sys_rst),
        .read_state_op(op[12]), .write_state_op(op[11]), .read_mask_op(op[10]), .write_mask_op(op[9]),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .priv_trap(priv_trap),
        .icc_upd(op[8]), .alu_sub(op[7]), .alu_a(alu_a), .alu_b(alu_b),
        .save_op(op[6]), .restore_op(op[5]), .trap_return_op(op[4]), .win_ovf(win_ovf), .win_unf(win_unf),
        .trap_take(op[3]), .trap_is_exc(op[2]), .irq_level(irq_level), .irq_accept(irq_accept),
        .error_mode(error_mode), .cp_insn(op[1]), .fp_insn(op[0]), .cp_trap(cp_trap), .fp_trap(fp_trap),
        .psr_out(psr_out), .wim_out(wim_out)
    );

    task automatic go(input logic [12:0] o, input logic [31:0] d = 32'h0);
        @(posedge mclk);
        op      <= o;
        wr_data <= d;
    endtask : go

    task automatic note(input logic [6:0] f, input logic [31:0] d = 32'h0, input logic [31:0] m = 32'h0);
        notes.push_back({f, d, m});
    endtask : note

    task automatic rd(input logic [31:0] d, input logic [31:0] m);
        note(F_RD, d, m);
        go(RS);
    endtask : rd

    task automatic wrap_up;
        if (notes.size() != 0) begin
            errors++;
            $display("unexpected at %0t: %0d results never appeared", $time, notes.size());
        end
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Every pulse is matched against the oldest note; a pulse with no note is itself a mismatch.
    always @(posedge mclk) begin
        logic [70:0] n;
        #1;
        if (ev != 7'h0) begin
            compares++;
            if (notes.size() == 0) begin
                errors++;
                $display("unexpected at %0t: pulses %b with nothing expected", $time, ev);
            end else begin
                n = notes.pop_front();
                if (ev !== n[70:64] || (rd_data & n[31:0]) !== n[63:32]) begin
                    errors++;
                    $display("unexpected at %0t: pulses %b data %h, wanted %b %h", $time, ev,
                             rd_data & n[31:0], n[70:64], n[63:32]);
                end
            end
        end
    end

    initial begin
        #20us;
        errors++;
        $display("unexpected at %0t: run hung", $time);
        wrap_up();
    end

    initial begin
        int          i;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] r;
        logic [32:0] s;
        logic [3:0]  f;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(32'h53000080, 32'hffffffff);
        note(F_RD, 32'h0, 32'hffffffff);
        go(RM);
        go(WS, 32'hffffffff);
        rd(32'h53f03fe7, 32'hffffffff);
        note(F_CP);
        go(CP);
        go(FP);
        go(WS, 32'h000000a0);
        note(F_CP);
        go(CP);
        note(F_FP);
        go(FP);
        // Three corner cases of the flags, then random operands; odd passes subtract.
        for (i = 0; i < 8; i++) begin
            a = (i == 0) ? 32'h7fffffff : (i == 1) ? 32'h0 : (i == 2) ? 32'hffffffff : $random(seed);
            b = (i < 3) ? 32'h1 : $random(seed);
            s = i[0] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
            r = s[31:0];
            f = {r[31], r == 32'h0, (a[31] == (b[31] ^ i[0])) && (r[31] != a[31]), s[32]};
            alu_a <= a;
            alu_b <= b;
            go(FL | (i[0] ? SB : 13'h0));
            rd({8'h0, f, 20'h0}, 32'h00f00000);
        end
        go(WS, 32'h000005a0);
        for (i = 0; i < 16; i++) begin
            if (i > 5)
                note(F_IA);
            irq_level <= i[3:0];
            go(13'h0);
        end
        irq_level <= 4'h0;
        go(WS, 32'h00000fa0);
        go(13'h0);
        note(F_IA);
        irq_level <= 4'hf;
        go(13'h0);
        irq_level <= 4'he;
        go(13'h0);
        go(WS, 32'h00000080);
        go(13'h0);
        irq_level <= 4'hf;
        go(13'h0);
        go(13'h0);
        irq_level <= 4'h0;
        go(WS, 32'h000000a0);
        go(WM, 32'h00000084);
        note(F_OV);
        go(SV);
        go(RE);
        note(F_UN);
        go(RE);
        note(F_UN);
        go(TR);
        rd(32'h1, 32'h7);
        go(WM, 32'h0);
        go(SV);
        go(SV);
        rd(32'h7, 32'h7);
        go(RE);
        rd(32'h0, 32'h7);
        go(TK);
        rd(32'hc7, 32'he7);
        go(WS, 32'h00000020);
        note(F_PT);
        go(RS);
        note(F_PT);
        go(WM, 32'h000000ff);
        go(TK);
        rd(32'h87, 32'he7);
        note(F_RD, 32'h0, 32'hffffffff);
        go(RM);
        go(TR);
        note(F_PT);
        go(RS);
        go(TK | EX);
        go(TK | EX);
        go(13'h0);
        go(RS);
        go(13'h0);
        go(13'h0);
        compares++;
        if (error_mode !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: core not halted", $time);
        end
        compares++;
        if ((psr_out & 32'hff0f3fff) !== 32'h530000c6 || wim_out !== 32'h0) begin
            errors++;
            $display("unexpected at %0t: register views %h %h", $time, psr_out, wim_out);
        end
        wrap_up();
    end
endmodule : ius_state_regs_test

// [rtl/ius_pkg.sv]
// Constants, field positions and the state-word layout of the integer core state registers.
// Assumes a single core clock and a pipeline that issues one operation per strobe.
package ius_pkg;

    // Bit positions within the processor state word.
    localparam int PSR_IMPL_LSB = 28;
    localparam int PSR_VER_LSB  = 24;
    localparam int PSR_N_BIT    = 23;
    localparam int PSR_Z_BIT    = 22;
    localparam int PSR_V_BIT    = 21;
    localparam int PSR_C_BIT    = 20;
    localparam int PSR_EC_BIT   = 13;
    localparam int PSR_EF_BIT   = 12;
    localparam int PSR_PIL_LSB  = 8;
    localparam int PSR_S_BIT    = 7;
    localparam int PSR_PS_BIT   = 6;
    localparam int PSR_ET_BIT   = 5;
    localparam int PSR_CWP_LSB  = 0;

    // Window count and the interrupt level that the mask level cannot block.
    localparam int         N_WIN   = 8;
    localparam logic [3:0] IRQ_NMI = 4'hf;

    typedef struct packed {
        logic       n;
        logic       z;
        logic       v;
        logic       c;
        logic       ec;
        logic       ef;
        logic [3:0] pil;
        logic       s;
        logic       ps;
        logic       et;
        logic [2:0] cwp;
    } ius_psr_t;

    // Values after reset.
    localparam ius_psr_t   PSR_RST = '{s: 1'b1, default: '0};
    localparam logic [7:0] WIM_RST = 8'h00;

    function automatic logic [31:0] ius_pack_psr(ius_psr_t p, logic [3:0] impl, logic [3:0] ver);
        logic [31:0] w;
        w = 32'h0;
        w[PSR_IMPL_LSB+:4] = impl;
        w[PSR_VER_LSB+:4]  = ver;
        w[PSR_N_BIT]       = p.n;
        w[PSR_Z_BIT]       = p.z;
        w[PSR_V_BIT]       = p.v;
        w[PSR_C_BIT]       = p.c;
        w[PSR_EC_BIT]      = p.ec;
        w[PSR_EF_BIT]      = p.ef;
        w[PSR_PIL_LSB+:4]  = p.pil;
        w[PSR_S_BIT]       = p.s;
        w[PSR_PS_BIT]      = p.ps;
        w[PSR_ET_BIT]      = p.et;
        w[PSR_CWP_LSB+:3]  = p.cwp;
        return w;
    endfunction : ius_pack_psr

    function automatic ius_psr_t ius_unpack_psr(logic [31:0] w);
        ius_psr_t p;
        p.n   = w[PSR_N_BIT];
        p.z   = w[PSR_Z_BIT];
        p.v   = w[PSR_V_BIT];
        p.c   = w[PSR_C_BIT];
        p.ec  = w[PSR_EC_BIT];
        p.ef  = w[PSR_EF_BIT];
        p.pil = w[PSR_PIL_LSB+:4];
        p.s   = w[PSR_S_BIT];
        p.ps  = w[PSR_PS_BIT];
        p.et  = w[PSR_ET_BIT];
        p.cwp = w[PSR_CWP_LSB+:3];
        return p;
    endfunction : ius_unpack_psr

endpackage : ius_pkg

// [rtl/ius_state_regs.sv]
// Processor state word and window invalid mask of the integer core, with their side effects.
// Assumes all strobes come from the pipeline on mclk, one instruction per cycle.
`timescale 1ns/1ps
module ius_state_regs #(
    // Arbitrary identification values.
    parameter logic [3:0] IMPL_CODE = 4'h5,
    parameter logic [3:0] VER_CODE  = 4'h3
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Privileged register access
    input  wire logic        read_state_op,
    input  wire logic        write_state_op,
    input  wire logic        read_mask_op,
    input  wire logic        write_mask_op,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] rd_data,
    output logic             rd_valid,
    output logic             priv_trap,
    // Condition flag update
    input  wire logic        icc_upd,
    input  wire logic        alu_sub,
    input  wire logic [31:0] alu_a,
    input  wire logic [31:0] alu_b,
    // Window operations
    input  wire logic        save_op,
    input  wire logic        restore_op,
    input  wire logic        trap_return_op,
    output logic             win_ovf,
    output logic             win_unf,
    // Traps and interrupts
    input  wire logic        trap_take,
    input  wire logic        trap_is_exc,
    input  wire logic [3:0]  irq_level,
    output logic             irq_accept,
    output logic             error_mode,
    // Unit instruction checks
    input  wire logic        cp_insn,
    input  wire logic        fp_insn,
    output logic             cp_trap,
    output logic             fp_trap,
    // Register views
    output logic      [31:0] psr_out,
    output logic      [31:0] wim_out
);

    typedef struct packed {
        logic [31:0] rd_data;
        logic        rd_valid;
        logic        priv_trap;
        logic        win_ovf;
        logic        win_unf;
        logic        irq_accept;
        logic        error_mode;
        logic        cp_trap;
        logic        fp_trap;
        logic [31:0] psr_out;
        logic [31:0] wim_out;
    } ius_out_t;

    localparam ius_out_t OUT_RST = '{
        psr_out: ius_pkg::ius_pack_psr(ius_pkg::PSR_RST, IMPL_CODE, VER_CODE),
        wim_out: {24'h000000, ius_pkg::WIM_RST},
        default: '0
    };

    ius_out_t         st;
    ius_out_t         next_st;
    ius_pkg::ius_psr_t cur;
    ius_pkg::ius_psr_t next_psr;
    logic [7:0]       cur_wim;
    logic [7:0]       next_wim;
    logic [32:0]      res;
    logic [32:0]      sres;
    logic [2:0]       cwp_dn;
    logic [2:0]       cwp_up;

    ius_tmr_if #(.W($bits(ius_pkg::ius_psr_t))) psr_if ();
    ius_tmr_if #(.W(8))                         wim_if ();

    ius_tmr_word #(
        .W   ($bits(ius_pkg::ius_psr_t)),
        .RST (ius_pkg::PSR_RST)
    ) u_psr_store (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .port    (psr_if.store)
    );

    ius_tmr_word #(
        .W   (8),
        .RST (ius_pkg::WIM_RST)
    ) u_wim_store (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .port    (wim_if.store)
    );

    assign cur      = psr_if.q;
    assign cur_wim  = wim_if.q;
    assign psr_if.d = next_psr;
    assign wim_if.d = next_wim;

    // A subtract is an add of the complement with carry in, so bit 32 is the borrow.
    assign res    = alu_sub ? ({1'b0, alu_a} - {1'b0, alu_b}) : ({1'b0, alu_a} + {1'b0, alu_b});
    // Sign-extended result, kept apart from the flag logic so the checks below do not copy it.
    assign sres   = alu_sub ? ({alu_a[31], alu_a} - {alu_b[31], alu_b}) : ({alu_a[31], alu_a} + {alu_b[31], alu_b});
    assign cwp_dn = cur.cwp - 3'h1;
    assign cwp_up = cur.cwp + 3'h1;

    always_comb begin
        next_st            = st;
        next_psr           = cur;
        next_wim           = cur_wim;
        next_st.rd_valid   = 1'b0;
        next_st.priv_trap  = 1'b0;
        next_st.win_ovf    = 1'b0;
        next_st.win_unf    = 1'b0;
        next_st.irq_accept = 1'b0;
        next_st.cp_trap    = 1'b0;
        next_st.fp_trap    = 1'b0;
        // Error mode freezes both words until reset, as the core has stopped.
        if (!st.error_mode) begin
            if (icc_upd && !(write_state_op && cur.s)) begin
                next_psr.n = res[31];
                next_psr.z = (res[31:0] == 32'h0);
                next_psr.v = alu_sub ? ((alu_a[31] != alu_b[31]) && (res[31] != alu_a[31]))
                                     : ((alu_a[31] == alu_b[31]) && (res[31] != alu_a[31]));
                next_psr.c = res[32];
            end
            if (write_state_op) begin
                if (cur.s) begin
                    // The class fields are never stored, so a write cannot reach them.
                    next_psr = ius_pkg::ius_unpack_psr(wr_data);
                end else begin
                    next_st.priv_trap = 1'b1;
                end
            end
            if (write_mask_op) begin
                if (cur.s) begin
                    next_wim = wr_data[ius_pkg::N_WIN-1:0];
                end else begin
                    next_st.priv_trap = 1'b1;
                end
            end
            if (read_state_op || read_mask_op) begin
                if (cur.s) begin
                    next_st.rd_valid = 1'b1;
                    next_st.rd_data  = read_state_op ? ius_pkg::ius_pack_psr(cur, IMPL_CODE, VER_CODE)
                                                     : {24'h000000, cur_wim};
                end else begin
                    next_st.priv_trap = 1'b1;
                end
            end
            if (save_op) begin
                if (cur_wim[cwp_dn]) begin
                    next_st.win_ovf = 1'b1;
                end else begin
                    next_psr.cwp = cwp_dn;
                end
            end
            if (restore_op || trap_return_op) begin
                if (cur_wim[cwp_up]) begin
                    next_st.win_unf = 1'b1;
                end else begin
                    next_psr.cwp = cwp_up;
                    if (trap_return_op) begin
                        next_psr.s  = cur.ps;
                        next_psr.et = 1'b1;
                    end
                end
            end
            // A trap outranks any other update of s, ps, et and cwp made in the same cycle.
            if (trap_take) begin
                next_psr.ps  = cur.s;
                next_psr.s   = 1'b1;
                next_psr.et  = 1'b0;
                next_psr.cwp = cwp_dn;
                if (trap_is_exc && !cur.et) begin
                    next_st.error_mode = 1'b1;
                end
            end
            next_st.irq_accept = cur.et && (irq_level != 4'h0)
                && ((irq_level == ius_pkg::IRQ_NMI) || (irq_level > cur.pil));
            // No coprocessor exists, so the enable bit is stored but never consulted.
            next_st.cp_trap = cp_insn;
            next_st.fp_trap = fp_insn && !cur.ef;
        end
        next_st.psr_out = ius_pkg::ius_pack_psr(next_psr, IMPL_CODE, VER_CODE);
        next_st.wim_out = {24'h000000, next_wim};
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= OUT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data    = st.rd_data;
    assign rd_valid   = st.rd_valid;
    assign priv_trap  = st.priv_trap;
    assign win_ovf    = st.win_ovf;
    assign win_unf    = st.win_unf;
    assign irq_accept = st.irq_accept;
    assign error_mode = st.error_mode;
    assign cp_trap    = st.cp_trap;
    assign fp_trap    = st.fp_trap;
    assign psr_out    = st.psr_out;
    assign wim_out    = st.wim_out;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_live_trap;
        !error_mode && trap_take;
    endsequence

    sequence s_exc_blind;
        !error_mode && trap_take && trap_is_exc && !cur.et;
    endsequence

    sequence s_flag_update;
        !error_mode && icc_upd && !trap_take && !write_state_op;
    endsequence

    sequence s_clean_restore;
        !error_mode && (restore_op || trap_return_op) && !save_op && !trap_take && !write_state_op;
    endsequence

    sequence s_user_access;
        !error_mode && !cur.s && (write_state_op || read_state_op || write_mask_op || read_mask_op);
    endsequence

    a_impl_fixed: assert property (
        psr_out[ius_pkg::PSR_IMPL_LSB+:4] == IMPL_CODE
    ) else $error("Class field changed.");

    a_zero_flag: assert property (
        !error_mode && icc_upd && !trap_take && !write_state_op
        |=> psr_out[ius_pkg::PSR_Z_BIT] == ($past(res[31:0]) == 32'h0)
    ) else $error("Zero flag does not match result.");

    a_carry_flag: assert property (
        !error_mode && icc_upd && !trap_take && !write_state_op
        |=> cur.c == $past(res[32]) && cur.n == $past(res[31])
    ) else $error("Carry or negative flag wrong.");

    a_fp_gate: assert property (
        !error_mode && fp_insn |=> fp_trap == !$past(cur.ef)
    ) else $error("Float trap does not follow enable.");

    a_irq_gate: assert property (
        irq_accept |-> $past(cur.et) && ($past(irq_level) > $past(cur.pil) || $past(irq_level) == 4'hf)
    ) else $error("Interrupt accepted while gated.");

    a_nmi_accept: assert property (
        !error_mode && cur.et && irq_level == 4'hf |=> irq_accept
    ) else $error("Level 15 not accepted.");

    a_trap_state: assert property (
        s_live_trap |=> cur.ps == $past(cur.s) && cur.s && !cur.et
    ) else $error("Trap did not save supervisor bit.");

    a_trap_clears_et: assert property (
        s_live_trap |=> !psr_out[ius_pkg::PSR_ET_BIT] ##1 (!cur.et || $past(trap_return_op) || $past(write_state_op))
    ) else $error("Trap enable not cleared.");

    a_trap_cwp: assert property (
        s_live_trap |=> cur.cwp == $past(cur.cwp) - 3'h1
    ) else $error("Trap did not decrement window pointer.");

    a_err_entry: assert property (
        s_exc_blind |=> error_mode [*3]
    ) else $error("Error mode not entered or not held.");

    a_user_blocked: assert property (
        s_user_access |=> priv_trap && !rd_valid
    ) else $error("User access not refused.");

    a_win_overflow: assert property (
        !error_mode && save_op && !trap_take && !restore_op && !trap_return_op && !write_state_op
        |=> (win_ovf == $past(cur_wim[cwp_dn])) && (win_ovf ? cur.cwp == $past(cur.cwp) : cur.cwp == $past(cwp_dn))
    ) else $error("Save ignored the window mask.");

    a_ovf_flag: assert property (
        s_flag_update |=> cur.v == $past(sres[32] ^ sres[31])
    ) else $error("Overflow flag wrong.");

    a_neg_flag: assert property (
        s_flag_update |=> psr_out[ius_pkg::PSR_N_BIT] == $past(sres[31])
    ) else $error("Negative flag wrong.");

    a_cp_trap: assert property (
        !error_mode && cp_insn |=> cp_trap
    ) else $error("Coprocessor op did not trap.");

    a_restore_cwp: assert property (
        s_clean_restore
        |=> (win_unf == $past(cur_wim[cwp_up])) && (win_unf ? cur.cwp == $past(cur.cwp) : cur.cwp == $past(cwp_up))
    ) else $error("Restore ignored the window mask.");

    a_mask_write: assert property (
        !error_mode && cur.s && write_mask_op |=> wim_out == {24'h000000, $past(wr_data[7:0])}
    ) else $error("Mask write not stored.");

    a_fixed_fields: assert property (
        !error_mode && cur.s && write_state_op
        |=> psr_out[31:24] == {IMPL_CODE, VER_CODE} && psr_out[19:14] == 6'h00 && psr_out[4:3] == 2'h0
    ) else $error("Read-only field changed by a write.");

    a_frozen: assert property (
        error_mode |=> $stable(psr_out) && $stable(wim_out) && !rd_valid
    ) else $error("State changed in error mode.");

    a_irq_none: assert property (
        irq_level == 4'h0 |=> !irq_accept
    ) else $error("Level zero accepted.");

endmodule : ius_state_regs

// [rtl/ius_tmr_if.sv]
// Carrier between the state register logic and one triplicated storage word.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ius_tmr_if #(parameter int W = 8);
    logic [W-1:0] d;
    logic [W-1:0] q;
    modport src (output d, input q);
    modport store (input d, output q);
endinterface : ius_tmr_if

// [rtl/ius_tmr_word.sv]
// One word held in three copies with a majority vote on the way out.
// Assumes the writer presents the full next value every cycle.
`timescale 1ns/1ps
module ius_tmr_word #(
    parameter int           W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Storage port
    ius_tmr_if.store port
);

    typedef struct packed {
        logic [W-1:0] a;
        logic [W-1:0] b;
        logic [W-1:0] c;
    } ius_tmr_st_t;

    ius_tmr_st_t st;
    ius_tmr_st_t next_st;

    // All copies load the same value, so a single upset is outvoted and then overwritten.
    always_comb begin
        next_st.a = port.d;
        next_st.b = port.d;
        next_st.c = port.d;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= {RST, RST, RST};
        end else begin
            st <= next_st;
        end
    end

    assign port.q = (st.a & st.b) | (st.a & st.c) | (st.b & st.c);

endmodule : ius_tmr_word
